// File: tpf_pkg.sv
/*
 * Package for the flat-panel format and timing block: register indices,
 * field positions, reset values and mode encodings.
 * Assumes a single system clock; the host reaches the registers through
 * an indexed CRT-controller data port at 3B5h or 3D5h.
 */
package tpf_pkg;
    localparam logic [15:0] PORT_DATA_MONO   = 16'h03B5;
    localparam logic [15:0] PORT_DATA_COLOUR = 16'h03D5;
    localparam logic [7:0]  IDX_FORMAT       = 8'h09;
    localparam logic [7:0]  IDX_SYNC_POS     = 8'h0A;
    localparam logic [7:0]  IDX_SHADE        = 8'h0B;
    localparam int          FMT_DELAY_LSB    = 4;
    localparam int          FMT_DITHER_LSB   = 2;
    localparam int          SHADE_7_9_BIT    = 4;
    localparam int          SHADE_5_11_BIT   = 3;
    localparam logic [7:0]  FORMAT_MASK      = 8'h7F;
    localparam logic [7:0]  SHADE_MASK       = 8'h18;
    localparam logic [7:0]  FORMAT_RESET     = 8'h00;
    localparam logic [7:0]  SYNC_POS_RESET   = 8'h00;
    localparam logic [7:0]  SHADE_RESET      = 8'h00;
    localparam logic [2:0]  DOTS_PER_CHAR    = 3'h7;

    typedef enum logic [1:0] {
        TPF_WIDTH_9  = 2'h0,
        TPF_WIDTH_12 = 2'h1,
        TPF_WIDTH_18 = 2'h2
    } tpf_width_type;

    typedef enum logic [1:0] {
        TPF_FRM_16 = 2'h0,
        TPF_FRM_8  = 2'h1,
        TPF_FRM_4  = 2'h2,
        TPF_FRM_NONE = 2'h3
    } tpf_frame_type;

    typedef enum logic [2:0] {
        TPF_DITH_NONE = 3'h0,
        TPF_DITH_X2   = 3'h1,
        TPF_DITH_X4   = 3'h2,
        TPF_DITH_X8   = 3'h3,
        TPF_DITH_X16  = 3'h4
    } tpf_dither_type;
endpackage

// File: tpf_panel_timing.sv
/*
 * Panel format registers, dither/frame-modulation decode and panel line
 * sync timing for a TFT output path.
 * Assumes the host port strobes are synchronous to clk_sys_in, which is
 * the dot clock; the character and horizontal counters are kept here.
 */
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Operation
// R1 - Extension registers gated by unlock bit
// R2 - Data port at 3B5h mono, 3D5h colour
// R3 - Delay line sync 0-7 dot clocks
// R4 - Larger delay shifts image left
// R5 - Format field selects 9/12/18-bit data
// R6 - Line-sync position in character clocks
// R7 - Larger position shifts image left
// R8 - Top bit AND halve bit adds character
// R9 - Frame modulation depth from grey bits
// R10 - 16-frame dithering x4 or x2
// R11 - 8-frame dithering x8, x4, x2
// R12 - 4-frame dithering x16, x8, x4
// R13 - Bit 4 suppresses shades 7, 9
// R14 - Bit 3 suppresses shades 5, 11
// R15 - Reserved bits zero; unlisted means no dither
module tpf_panel_timing #(
    parameter int HCHAR_TOTAL = 100
) (
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_in,
    input  wire logic [15:0]            io_addr_in,
    input  wire logic                   io_wr_in,
    input  wire logic                   io_rd_in,
    input  wire logic [7:0]             io_wdata_in,
    input  wire logic [7:0]             crtc_index_in,
    input  wire logic                   colour_mode_in,
    input  wire logic                   extension_unlock_bit_in,
    input  wire logic                   grey_mode_select_in,
    input  wire logic                   grey_control_high_in,
    input  wire logic                   grey_control_low_in,
    input  wire logic                   dither_enable_in,
    input  wire logic                   sequencer_clock_halve_bit_in,
    output logic [7:0]                  io_rdata_out,
    output logic                        io_rvalid_out,
    output tpf_pkg::tpf_width_type      width_out,
    output tpf_pkg::tpf_frame_type      frame_mod_out,
    output tpf_pkg::tpf_dither_type     dither_out,
    output logic                        shade_7_9_off_out,
    output logic                        shade_5_11_off_out,
    output logic                        panel_line_sync_out
);
    import tpf_pkg::*;

    // Every check runs on the dot clock and sleeps through reset
    default clocking cb_dot @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    logic [7:0] format_q;
    logic [7:0] sync_pos_q;
    logic [7:0] shade_q;

    //////////////////////////////////////////////////////////////////////////
    // Host port decode
    wire [15:0] port_addr = colour_mode_in ? PORT_DATA_COLOUR
                                           : PORT_DATA_MONO; // see R2
    wire        port_hit  = (io_addr_in == port_addr)
                            && extension_unlock_bit_in; // see R1
    wire        hit_fmt   = port_hit && (crtc_index_in == IDX_FORMAT);
    wire        hit_pos   = port_hit && (crtc_index_in == IDX_SYNC_POS);
    wire        hit_shade = port_hit && (crtc_index_in == IDX_SHADE);
    wire [7:0]  rd_mux    = hit_fmt   ? format_q :
                            hit_pos   ? sync_pos_q :
                            hit_shade ? shade_q : 8'h00;
    wire        rd_hit    = io_rd_in && (hit_fmt || hit_pos || hit_shade);

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            format_q   <= FORMAT_RESET;
            sync_pos_q <= SYNC_POS_RESET;
            shade_q    <= SHADE_RESET; // see R13 see R14
        end else if (io_wr_in) begin
            if (hit_fmt) begin
                format_q <= io_wdata_in & FORMAT_MASK; // see R15
            end
            if (hit_pos) begin
                sync_pos_q <= io_wdata_in;
            end
            if (hit_shade) begin
                shade_q <= io_wdata_in & SHADE_MASK; // see R15
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            io_rdata_out  <= 8'h00;
            io_rvalid_out <= 1'b0;
        end else begin
            io_rdata_out  <= rd_hit ? rd_mux : 8'h00;
            io_rvalid_out <= rd_hit;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Format, frame modulation and dither decode
    wire [1:0] fmt_field = format_q[1:0];
    wire [1:0] dith_opt  = format_q[FMT_DITHER_LSB +: 2];
    wire [2:0] delay_sel = format_q[FMT_DELAY_LSB +: 3];

    wire tpf_width_type width_d = fmt_field[0] ? TPF_WIDTH_18 :
                                  fmt_field[1] ? TPF_WIDTH_12
                                               : TPF_WIDTH_9; // see R5

    wire is_16_plain = !grey_mode_select_in && !grey_control_high_in
                       && !grey_control_low_in;
    wire is_16_dith  = !grey_mode_select_in && grey_control_high_in
                       && grey_control_low_in && dither_enable_in;
    wire is_8        = grey_mode_select_in && grey_control_high_in
                       && !grey_control_low_in;
    wire is_4        = grey_mode_select_in && !grey_control_high_in
                       && grey_control_low_in;

    wire tpf_frame_type frame_d = (is_16_plain || is_16_dith) ? TPF_FRM_16 :
                                  is_8 ? TPF_FRM_8 :
                                  is_4 ? TPF_FRM_4 : TPF_FRM_NONE; // see R9

    wire tpf_dither_type d16 = (dith_opt == 2'h0) ? TPF_DITH_X4 :
                               (dith_opt == 2'h1) ? TPF_DITH_X2
                                                  : TPF_DITH_NONE; // see R10
    wire tpf_dither_type d8  = (dith_opt == 2'h0) ? TPF_DITH_X8 :
                               (dith_opt == 2'h1) ? TPF_DITH_X4 :
                               (dith_opt == 2'h3) ? TPF_DITH_X2
                                                  : TPF_DITH_NONE; // see R11
    wire tpf_dither_type d4  = (dith_opt == 2'h0) ? TPF_DITH_X16 :
                               (dith_opt == 2'h1) ? TPF_DITH_X8 :
                               (dith_opt == 2'h3) ? TPF_DITH_X4
                                                  : TPF_DITH_NONE; // see R12
    // Option 10 and unknown grey combinations fall back to no dithering
    wire tpf_dither_type dither_d =
        is_16_dith                   ? d16 :
        (is_8 && dither_enable_in)   ? d8  :
        (is_4 && dither_enable_in)   ? d4  : TPF_DITH_NONE; // see R15

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            width_out          <= TPF_WIDTH_9;
            frame_mod_out      <= TPF_FRM_16;
            dither_out         <= TPF_DITH_NONE;
            shade_7_9_off_out  <= 1'b0;
            shade_5_11_off_out <= 1'b0;
        end else begin
            width_out          <= width_d;
            frame_mod_out      <= frame_d;
            dither_out         <= dither_d;
            shade_7_9_off_out  <= shade_q[SHADE_7_9_BIT]; // see R13
            shade_5_11_off_out <= shade_q[SHADE_5_11_BIT]; // see R14
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Character and horizontal counters, line sync placement
    logic [2:0] dot_q;
    logic [7:0] hchar_q;
    logic       extra_q;
    logic [7:0] pulse_sr_q;

    wire       char_end   = (dot_q == DOTS_PER_CHAR);
    wire       line_end   = char_end
                            && (hchar_q == 8'(HCHAR_TOTAL - 1));
    // Later sync relative to pixels moves the picture left
    wire       pos_match  = char_end && (hchar_q == sync_pos_q); // see R6 see R7
    wire       add_char   = sync_pos_q[7]
                            && sequencer_clock_halve_bit_in; // see R8
    wire       char_fire  = add_char ? (extra_q && char_end) : pos_match;
    // Shift register gives delays 0..7 with no counter compare per dot
    wire [7:0] pulse_sr_d = {pulse_sr_q[6:0], char_fire};

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            dot_q      <= 3'h0;
            hchar_q    <= 8'h00;
            extra_q    <= 1'b0;
            pulse_sr_q <= 8'h00;
        end else begin
            dot_q      <= dot_q + 3'h1;
            hchar_q    <= line_end ? 8'h00
                        : (char_end ? hchar_q + 8'h01 : hchar_q);
            extra_q    <= pos_match ? 1'b1 : (char_end ? 1'b0 : extra_q);
            pulse_sr_q <= pulse_sr_d;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            panel_line_sync_out <= 1'b0;
        end else begin
            panel_line_sync_out <= pulse_sr_d[delay_sel]; // see R3 see R4
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_locked_write;
        io_wr_in && !extension_unlock_bit_in;
    endsequence

    // Position hit with the extra character due and no tap delay
    sequence s_extra_armed;
        pos_match && add_char && delay_sel == 3'h0;
    endsequence

    // Only the tap in use when the pulse leaves matters
    sequence s_fire_delay_3;
        char_fire ##3 delay_sel == 3'h3;
    endsequence

    a_locked_no_write: assert property ( // see R1
        s_locked_write |=> $stable(format_q) && $stable(sync_pos_q)
        && $stable(shade_q))
        else $error("locked write changed a panel register");

    a_reserved_zero: assert property ( // see R15
        format_q[7] == 1'b0 && (shade_q & ~SHADE_MASK) == 8'h00)
        else $error("reserved bit set");

    a_width_18: assert property ( // see R5
        format_q[0] |=> width_out == TPF_WIDTH_18)
        else $error("low format bit must give 18-bit");

    a_width_12: assert property ( // see R5
        format_q[1:0] == 2'h2 |=> width_out == TPF_WIDTH_12)
        else $error("format 10 must give 12-bit");

    a_sync_delay: assert property ( // see R3
        s_fire_delay_3 |=> panel_line_sync_out)
        else $error("line sync delay wrong");

    a_pos_sync: assert property ( // see R6
        pos_match && !add_char && delay_sel == 3'h0 |=> panel_line_sync_out)
        else $error("line sync missed position");

    a_extra_quiet: assert property ( // see R8
        s_extra_armed |=> !panel_line_sync_out)
        else $error("extra character delay fired early");

    a_extra_char: assert property ( // see R8
        s_extra_armed ##8 (add_char && delay_sel == 3'h0)
        |=> panel_line_sync_out)
        else $error("extra character delay wrong");

    a_dither_8x8: assert property ( // see R11
        is_8 && dither_enable_in && dith_opt == 2'h0
        |=> dither_out == TPF_DITH_X8)
        else $error("8-frame x8 dither wrong");

    a_dither_4x16: assert property ( // see R12
        is_4 && dither_enable_in && dith_opt == 2'h0
        |=> dither_out == TPF_DITH_X16)
        else $error("4-frame x16 dither wrong");

    a_dither_16x2: assert property ( // see R10
        is_16_dith && dith_opt == 2'h1 |=> dither_out == TPF_DITH_X2
        && frame_mod_out == TPF_FRM_16)
        else $error("16-frame x2 dither wrong");

    a_frame_plain: assert property ( // see R9
        is_16_plain |=> frame_mod_out == TPF_FRM_16
        && dither_out == TPF_DITH_NONE)
        else $error("16-frame plain mode wrong");

    a_shade_bits: assert property ( // see R13 see R14
        ##1 shade_7_9_off_out == $past(shade_q[SHADE_7_9_BIT])
        && shade_5_11_off_out == $past(shade_q[SHADE_5_11_BIT]))
        else $error("shade suppress output wrong");

endmodule // tpf_panel_timing
`default_nettype wire

// File: tpf_panel_model.sv
/*
 * Panel-side model: timestamps each panel line-sync pulse and counts
 * each dot clock after the first on which a pulse is still high.
 * Assumes the dot clock and synchronous reset of the block under test.
 */
`timescale 1ns/1ps
`default_nettype none
module tpf_panel_model (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic sync_in,
    output var  int   pulses_out,
    output var  int   last_out,
    output var  int   prev_out,
    output var  int   wide_out
);
    int   cyc_q;
    logic sync_q;

    // Panel latches a line on each rising sync edge
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cyc_q      <= 0;
            sync_q     <= 1'b0;
            pulses_out <= 0;
            last_out   <= 0;
            prev_out   <= 0;
            wide_out   <= 0;
        end else begin
            cyc_q  <= cyc_q + 1;
            sync_q <= sync_in;
            if (sync_in && !sync_q) begin
                pulses_out <= pulses_out + 1;
                prev_out   <= last_out;
                last_out   <= cyc_q;
            end
            if (sync_in && sync_q) begin
                wide_out <= wide_out + 1;
            end
        end
    end
endmodule // tpf_panel_model
`default_nettype wire

// File: testbench.sv
/*
 * Self-checking bench for the panel format and timing block.
 * Assumes tpf_pkg and tpf_panel_model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tpf_pkg::*;
    localparam int HC   = 136;
    localparam int LINE = HC * 8;
    logic clk_sys_in, rst_in, io_wr_in, io_rd_in, colour, unlock;
    logic gm, gh, gl, de, halve, rv, s79, s511, sync;
    logic [15:0] io_addr_in;
    logic [7:0]  io_wdata_in, idx, rdata, rdv, d, e;
    tpf_width_type  width;
    tpf_frame_type  frame;
    tpf_dither_type dith;
    int err_count, checks, pulses, last, prev, wide, base, ph;
    int tp[4] = '{0, 135, 130, 130};
    int td[4] = '{7, 0, 0, 3};
    int th[4] = '{0, 0, 1, 0};

    tpf_panel_timing #(.HCHAR_TOTAL(HC)) uut (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in),
        .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in), .crtc_index_in(idx),
        .colour_mode_in(colour), .extension_unlock_bit_in(unlock),
        .grey_mode_select_in(gm), .grey_control_high_in(gh),
        .grey_control_low_in(gl), .dither_enable_in(de),
        .sequencer_clock_halve_bit_in(halve), .io_rdata_out(rdata),
        .io_rvalid_out(rv), .width_out(width), .frame_mod_out(frame),
        .dither_out(dith), .shade_7_9_off_out(s79),
        .shade_5_11_off_out(s511), .panel_line_sync_out(sync));
    tpf_panel_model panel (.clk_in(clk_sys_in), .rst_in(rst_in),
        .sync_in(sync), .pulses_out(pulses), .last_out(last),
        .prev_out(prev), .wide_out(wide));

    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [15:0] port(input logic c);
        return c ? PORT_DATA_COLOUR : PORT_DATA_MONO;
    endfunction
    // Strobe held over exactly one rising edge; answer sampled after it
    task automatic acc(input logic [15:0] a, input logic w,
                       input logic [7:0] i, input logic [7:0] wd);
        @(negedge clk_sys_in);
        io_addr_in  = a;
        io_wr_in    = w;
        io_rd_in    = !w;
        idx         = i;
        io_wdata_in = wd;
        @(negedge clk_sys_in);
        io_wr_in = 1'b0;
        io_rd_in = 1'b0;
        rdv      = {7'h0, rv} ? rdata : 8'h00;
        d        = {7'h0, rv};
        repeat (2) @(negedge clk_sys_in);
    endtask
    function automatic tpf_frame_type exp_frame(input logic [3:0] g);
        casez (g)
            4'b000?: return TPF_FRM_16;
            4'b0111: return TPF_FRM_16;
            4'b110?: return TPF_FRM_8;
            4'b101?: return TPF_FRM_4;
            default: return TPF_FRM_NONE;
        endcase
    endfunction
    function automatic tpf_dither_type exp_dith(input logic [3:0] g,
                                                input logic [1:0] o);
        if (!g[0] || g[2:1] == 2'b00) return TPF_DITH_NONE;
        case ({exp_frame(g), o})
            {TPF_FRM_16, 2'h0}: return TPF_DITH_X4;
            {TPF_FRM_16, 2'h1}: return TPF_DITH_X2;
            {TPF_FRM_8, 2'h0}:  return TPF_DITH_X8;
            {TPF_FRM_8, 2'h1}:  return TPF_DITH_X4;
            {TPF_FRM_8, 2'h3}:  return TPF_DITH_X2;
            {TPF_FRM_4, 2'h0}:  return TPF_DITH_X16;
            {TPF_FRM_4, 2'h1}:  return TPF_DITH_X8;
            {TPF_FRM_4, 2'h3}:  return TPF_DITH_X4;
            default:            return TPF_DITH_NONE;
        endcase
    endfunction
    function automatic tpf_width_type exp_width(input logic [1:0] f);
        return f[0] ? TPF_WIDTH_18 : f[1] ? TPF_WIDTH_12 : TPF_WIDTH_9;
    endfunction
    function automatic int exp_phase(input int k);
        int extra;
        extra = (tp[k] > 127 && th[k] == 1) ? 8 : 0;
        return (base + 8 * tp[k] + td[k] + extra) % LINE;
    endfunction
    // Phase of the third sync after a change; early pulses may be stale
    task automatic line(input int p, input int dl, input int h);
        int n;
        int w0;
        acc(port(colour), 1'b1, IDX_SYNC_POS, p[7:0]);
        acc(port(colour), 1'b1, IDX_FORMAT, {1'b0, dl[2:0], 4'h0});
        halve = h[0];
        // A delay change may stretch a pulse still in the tap line
        repeat (9) @(negedge clk_sys_in);
        n = pulses;
        w0 = wide;
        for (int w = 0; w < 4000 && pulses < n + 3; w++) @(negedge clk_sys_in);
        if (pulses < n + 3) begin
            err_count++;
            test_done();
        end
        check(last - prev, LINE);
        check(wide - w0, 0);
        ph = last % LINE;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_in, io_wr_in, io_rd_in, colour, unlock} = 5'b10000;
        {gm, gh, gl, de, halve} = 5'h00;
        io_addr_in = 16'h0000;
        io_wdata_in = 8'h00;
        idx = 8'h00;
        err_count = 0;
        checks = 0;
        void'($urandom(43677));
        repeat (4) @(negedge clk_sys_in);
        rst_in = 1'b0;
        unlock = 1'b1;
        acc(port(colour), 1'b0, IDX_SHADE, 8'h00);
        check({rdv, d}, {SHADE_RESET, 8'h01});
        for (int i = 0; i < 6; i++) begin
            colour = i[0];
            e = 8'($urandom);
            acc(port(colour), 1'b1, IDX_FORMAT + 8'(i % 3), e);
            e &= (i % 3 == 0) ? FORMAT_MASK
               : (i % 3 == 1) ? 8'hFF : SHADE_MASK;
            acc(port(colour), 1'b0, IDX_FORMAT + 8'(i % 3), 8'h00);
            check(rdv, e);
        end
        acc(port(1'b1), 1'b1, IDX_SHADE, 8'hFF);
        acc(port(1'b1), 1'b0, IDX_SHADE + 8'h01, 8'h00);
        check({rdv, d}, 16'h0000);
        acc(port(1'b0), 1'b0, IDX_SHADE, 8'h00);
        check({rdv, d}, 16'h0000);
        unlock = 1'b0;
        acc(port(1'b1), 1'b1, IDX_SHADE, 8'h00);
        acc(port(1'b1), 1'b0, IDX_SHADE, 8'h00);
        check({rdv, d}, 16'h0000);
        unlock = 1'b1;
        acc(port(1'b1), 1'b0, IDX_SHADE, 8'h00);
        check({rdv, d}, {SHADE_MASK, 8'h01});
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            acc(port(colour), 1'b1, IDX_SHADE, {3'h0, s[1:0], 3'h0});
            check({s79, s511}, s[1:0]);
        end
        for (int f = 0; f < 4; f++) begin
            acc(port(colour), 1'b1, IDX_FORMAT, f[7:0]);
            check(width, exp_width(f[1:0]));
        end
        for (int k = 0; k < 64; k++) begin
            {gm, gh, gl, de} = k[5:2];
            acc(port(colour), 1'b1, IDX_FORMAT, {4'h0, k[1:0], 2'h0});
            check(frame, exp_frame(k[5:2]));
            check(dith, exp_dith(k[5:2], k[1:0]));
        end
        $display("test decode done");
        line(0, 0, 0);
        base = ph;
        for (int j = 0; j < 7; j++) begin
            if (j > 3) begin
                tp[j % 4] = $urandom_range(127);
                td[j % 4] = $urandom_range(7);
                th[j % 4] = $urandom_range(1);
            end
            line(tp[j % 4], td[j % 4], th[j % 4]);
            check(ph, exp_phase(j % 4));
        end
        $display("test line sync done");
        test_done();
    end
endmodule // testbench
`default_nettype wire
